/* File: core/mfc_params.svh */
// Offsets, reset values and timing counts for the motor field control block
`ifndef MFC_PARAMS_SVH
`define MFC_PARAMS_SVH
`define MFC_OFF_ECON_DELAY   12'h000
`define MFC_OFF_CTRL         12'h004
`define MFC_OFF_FIRE_LIMIT   12'h008
`define MFC_OFF_MAX1         12'h00c
`define MFC_OFF_MAX2         12'h010
`define MFC_OFF_MIN          12'h014
`define MFC_OFF_FB_SCALE     12'h018
`define MFC_OFF_STATUS       12'h01c
`define MFC_OFF_GAINS        12'h020
`define MFC_OFF_DEMAND       12'h024
`define MFC_CTL_FIELD_EN     0
`define MFC_CTL_SEL2         1
`define MFC_CTL_ECON_EN      2
`define MFC_CTL_FLD_NORM     3
`define MFC_CTL_VLT_DBL      4
`define MFC_CTL_DIRECT       5
`define MFC_CTL_IR_SRC       6
`define MFC_CTL_FULL         7
`define MFC_CTL_HALVE        8
`define MFC_CTL_QUARTER      9
`define MFC_CTRL_RESET       10'h008
`define MFC_ECON_RESET       8'h1e
`define MFC_FIRE_RESET       10'h3e8
`define MFC_FIRE_MAX         10'h3e8
`define MFC_MAX1_RESET       10'h3e8
`define MFC_MAX2_RESET       10'h1f4
`define MFC_MIN_RESET        10'h1f4
`define MFC_FB_RESET         8'hcc
`define MFC_FB_EARLY_LO      8'h65
`define MFC_FB_EARLY_HI      8'h6e
`define MFC_CLK_HZ           100000000
`define MFC_SECOND_S         1
`define MFC_CYC_PER_SEC      (`MFC_SECOND_S * `MFC_CLK_HZ)
`endif

/* File: core/mfc_pkg.sv */
// Types for the motor field control block
package mfc_pkg;
   typedef enum logic [1:0] {
      MFC_IDLE,
      MFC_WR,
      MFC_WRESP
   } mfc_wr_state_e;
   typedef logic [9:0] mfc_val_t;
endpackage : mfc_pkg

/* File: core/mfc_field_ctrl.sv */
// Motor field control settings, economy timer and AXI4-Lite register slave
`timescale 1ns/1ps
`include "mfc_params.svh"
module mfc_field_ctrl #(
   parameter int unsigned CYC_PER_SEC = `MFC_CYC_PER_SEC,
   parameter bit          EARLY_CARD  = 1'b0
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        drive_enable,
   input  wire logic [9:0]  emf_loop_demand,
   input  wire logic [9:0]  field_loop_angle,
   input  wire logic [10:0] speed_err_integral,
   input  wire logic [10:0] final_current_demand,
   output logic [9:0]       field_demand,
   output logic [9:0]       firing_angle,
   output logic [10:0]      ir_comp_input,
   output logic [2:0]       field_gain_shift,
   output logic             field_integral_boost,
   output logic             voltage_integral_double,
   output logic             full_control,
   output logic             loop_bypass,
   output logic [9:0]       speed_gain_num,
   output logic [9:0]       speed_gain_den
);
   logic [7:0]  econ_delay_reg;
   logic [9:0]  ctrl_reg;
   mfc_pkg::mfc_val_t fire_limit_reg;
   mfc_pkg::mfc_val_t max1_reg;
   mfc_pkg::mfc_val_t max2_reg;
   mfc_pkg::mfc_val_t min_reg;
   logic [7:0]  fb_scale_reg;
   logic        auto_sel2_reg;
   logic [7:0]  sec_cnt_reg;
   logic [31:0] tick_cnt_reg;
   mfc_pkg::mfc_wr_state_e wr_state_reg;
   logic [11:0] awaddr_reg;
   logic        aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        w_held_reg;
   logic        wr_fire;
   logic [31:0] wr_val;
   logic        sel2_eff;
   mfc_pkg::mfc_val_t sel_max;
   mfc_pkg::mfc_val_t clamped;
   mfc_pkg::mfc_val_t angle_src;

   // Write side: address and data accepted in either order
   assign wr_fire = (wr_state_reg == mfc_pkg::MFC_WR);
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wr_val[i*8 +: 8] = wstrb_reg[i] ? wdata_reg[i*8 +: 8] : 8'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wr_state_reg  <= mfc_pkg::MFC_IDLE;
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         awaddr_reg    <= 12'h000;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         case (wr_state_reg)
            mfc_pkg::MFC_IDLE: begin
               if (s_axi_awvalid && !aw_held_reg && !s_axi_awready) begin
                  s_axi_awready <= 1'b1;
                  awaddr_reg    <= s_axi_awaddr;
                  aw_held_reg   <= 1'b1;
               end
               if (s_axi_wvalid && !w_held_reg && !s_axi_wready) begin
                  s_axi_wready <= 1'b1;
                  wdata_reg    <= s_axi_wdata;
                  wstrb_reg    <= s_axi_wstrb;
                  w_held_reg   <= 1'b1;
               end
               if (aw_held_reg && w_held_reg) begin
                  wr_state_reg <= mfc_pkg::MFC_WR;
               end
            end
            mfc_pkg::MFC_WR: begin
               aw_held_reg  <= 1'b0;
               w_held_reg   <= 1'b0;
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= (awaddr_reg[11:2] > `MFC_OFF_DEMAND >> 2) ? 2'h2 : 2'h0;
               wr_state_reg <= mfc_pkg::MFC_WRESP;
            end
            mfc_pkg::MFC_WRESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_state_reg <= mfc_pkg::MFC_IDLE;
               end
            end
            default: wr_state_reg <= mfc_pkg::MFC_IDLE;
         endcase
      end
   end

   // Settings registers; on sub-word writes, bytes without a strobe are written as zero, but econ_delay_reg keeps its value without strobe 0
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         econ_delay_reg <= `MFC_ECON_RESET;
         fire_limit_reg <= `MFC_FIRE_RESET;
         max1_reg       <= `MFC_MAX1_RESET;
         max2_reg       <= `MFC_MAX2_RESET;
         min_reg        <= `MFC_MIN_RESET;
         fb_scale_reg   <= `MFC_FB_RESET;
      end else if (wr_fire) begin
         case (awaddr_reg)
            `MFC_OFF_ECON_DELAY: if (wstrb_reg[0]) econ_delay_reg <= wr_val[7:0];
            `MFC_OFF_FIRE_LIMIT: if (wr_val[9:0] <= `MFC_FIRE_MAX) fire_limit_reg <= wr_val[9:0];
            `MFC_OFF_MAX1: if (wr_val[9:0] <= `MFC_FIRE_MAX) max1_reg <= wr_val[9:0];
            `MFC_OFF_MAX2: if (wr_val[9:0] <= `MFC_FIRE_MAX) max2_reg <= wr_val[9:0];
            `MFC_OFF_MIN: if (wr_val[9:0] <= `MFC_FIRE_MAX) min_reg <= wr_val[9:0];
            `MFC_OFF_FB_SCALE: begin
               if (!EARLY_CARD || (wr_val[7:0] >= `MFC_FB_EARLY_LO &&
                                   wr_val[7:0] <= `MFC_FB_EARLY_HI)) begin
                  fb_scale_reg <= wr_val[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ctrl_reg <= `MFC_CTRL_RESET;
      end else if (wr_fire && awaddr_reg == `MFC_OFF_CTRL) begin
         ctrl_reg <= wr_val[9:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b || drive_enable || !ctrl_reg[`MFC_CTL_ECON_EN]) begin
         tick_cnt_reg  <= 32'h0000_0000;
         sec_cnt_reg   <= 8'h00;
         auto_sel2_reg <= 1'b0;
      end else if (sec_cnt_reg >= econ_delay_reg) begin
         auto_sel2_reg <= 1'b1;
      end else if (tick_cnt_reg >= CYC_PER_SEC - 1) begin
         tick_cnt_reg <= 32'h0000_0000;
         sec_cnt_reg  <= sec_cnt_reg + 8'h01;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
   end

   assign sel2_eff = ctrl_reg[`MFC_CTL_ECON_EN] ? auto_sel2_reg : ctrl_reg[`MFC_CTL_SEL2];
   assign sel_max = sel2_eff ? max2_reg : max1_reg;
   always_comb begin
      clamped = emf_loop_demand;
      if (clamped > sel_max) clamped = sel_max;
      if (clamped < min_reg) clamped = min_reg;
   end
   assign angle_src = ctrl_reg[`MFC_CTL_DIRECT] ? max2_reg : field_loop_angle;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         field_demand            <= 10'h000;
         firing_angle            <= 10'h000;
         ir_comp_input           <= 11'h000;
         field_gain_shift        <= 3'h0;
         field_integral_boost    <= 1'b0;
         voltage_integral_double <= 1'b0;
         full_control            <= 1'b0;
         loop_bypass             <= 1'b0;
         speed_gain_num          <= 10'h000;
         speed_gain_den          <= 10'h000;
      end else begin
         field_demand <= clamped;
         firing_angle <= (angle_src > fire_limit_reg) ? fire_limit_reg : angle_src;
         loop_bypass <= ctrl_reg[`MFC_CTL_DIRECT];
         ir_comp_input <= ctrl_reg[`MFC_CTL_IR_SRC] ? final_current_demand : speed_err_integral;
         field_gain_shift <= {1'b0, ctrl_reg[`MFC_CTL_QUARTER], 1'b0} +
                             {2'b00, ctrl_reg[`MFC_CTL_HALVE]};
         field_integral_boost <= !ctrl_reg[`MFC_CTL_FLD_NORM];
         voltage_integral_double <= ctrl_reg[`MFC_CTL_VLT_DBL];
         full_control <= ctrl_reg[`MFC_CTL_FULL];
         // speed gain ratio max1 over demand
         speed_gain_num <= ctrl_reg[`MFC_CTL_FIELD_EN] ? max1_reg : 10'h001;
         speed_gain_den <= ctrl_reg[`MFC_CTL_FIELD_EN] ? clamped : 10'h001;
      end
   end

   // Read side: one read at a time, answer one cycle after the address
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid) begin
            if (s_axi_rready) s_axi_rvalid <= 1'b0;
         end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr)
               `MFC_OFF_ECON_DELAY: s_axi_rdata <= {24'h0, econ_delay_reg};
               `MFC_OFF_CTRL: s_axi_rdata <= {22'h0, ctrl_reg};
               `MFC_OFF_FIRE_LIMIT: s_axi_rdata <= {22'h0, fire_limit_reg};
               `MFC_OFF_MAX1: s_axi_rdata <= {22'h0, max1_reg};
               `MFC_OFF_MAX2: s_axi_rdata <= {22'h0, max2_reg};
               `MFC_OFF_MIN: s_axi_rdata <= {22'h0, min_reg};
               `MFC_OFF_FB_SCALE: s_axi_rdata <= {24'h0, fb_scale_reg};
               `MFC_OFF_STATUS: s_axi_rdata <= {22'h0, sel2_eff, auto_sel2_reg, sec_cnt_reg};
               `MFC_OFF_GAINS: s_axi_rdata <= {29'h0, field_gain_shift};
               `MFC_OFF_DEMAND: s_axi_rdata <= {6'h0, firing_angle, 6'h0, field_demand};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
      end
   end

   econ_fire_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ctrl_reg[2] && !drive_enable && sec_cnt_reg >= econ_delay_reg)
      |=> (auto_sel2_reg || drive_enable || !ctrl_reg[2]))
      else $error("economy select missed");
   econ_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      drive_enable |=> (sec_cnt_reg == 8'h00 && !auto_sel2_reg))
      else $error("economy timer not cleared");
   angle_endstop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ##1 firing_angle <= $past(fire_limit_reg)) else $error("angle past endstop");
   direct_angle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ctrl_reg[5] && max2_reg <= fire_limit_reg) |=> firing_angle == $past(max2_reg))
      else $error("direct angle wrong");
   demand_clamp_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (min_reg <= sel_max) |=> (field_demand <= $past(sel_max)))
      else $error("demand above max");
   sel_manual_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!ctrl_reg[2] && ctrl_reg[1]) |-> sel_max == max2_reg) else $error("max2 not used");
   ir_src_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ctrl_reg[6] |=> ir_comp_input == $past(final_current_demand))
      else $error("ir source wrong");
   gain_both_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ctrl_reg[8] && ctrl_reg[9]) |=> field_gain_shift == 3'h3) else $error("gain shift");
   fld_boost_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !ctrl_reg[3] |=> field_integral_boost) else $error("boost missing");
   vlt_dbl_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ctrl_reg[4] |=> voltage_integral_double) else $error("double missing");
   econ_owns_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ctrl_reg[2] && drive_enable) |=> (!sel2_eff || !ctrl_reg[2]))
      else $error("auto select kept");
   sel_user_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !ctrl_reg[2] |-> sel2_eff == ctrl_reg[1]) else $error("user select ignored");
   direct_bypass_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> loop_bypass == $past(ctrl_reg[5])) else $error("bypass wrong");
   full_ctrl_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> full_control == $past(ctrl_reg[7])) else $error("full control wrong");
   gain_shift_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> field_gain_shift == {1'b0, $past(ctrl_reg[9]), $past(ctrl_reg[8])})
      else $error("gain shift wrong");
   speed_ratio_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ctrl_reg[0] |=> (speed_gain_num == $past(max1_reg) &&
                       speed_gain_den == $past(clamped)))
      else $error("speed gain ratio wrong");
   ir_src0_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !ctrl_reg[6] |=> ir_comp_input == $past(speed_err_integral))
      else $error("ir integral source wrong");
   early_scale_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (EARLY_CARD && wr_fire && awaddr_reg == `MFC_OFF_FB_SCALE &&
       (wr_val[7:0] < `MFC_FB_EARLY_LO || wr_val[7:0] > `MFC_FB_EARLY_HI))
      |=> fb_scale_reg == $past(fb_scale_reg))
      else $error("scale code accepted");
endmodule : mfc_field_ctrl

/* File: testbench/mfc_bridge_model.sv */
// Behavioural far side: field loops feeding the block and the thyristor bridge
`timescale 1ns/1ps
module mfc_bridge_model #(
   parameter bit BRIDGE_MODE_LINK = 1'b1
) (
   input  wire logic        clk_sys,
   input  wire logic        full_control,
   input  wire logic [9:0]  angle_req,
   input  wire logic [9:0]  demand_req,
   output logic [9:0]       field_loop_angle,
   output logic [9:0]       emf_loop_demand,
   output logic [10:0]      speed_err_integral,
   output logic [10:0]      final_current_demand,
   output logic             bridge_full
);
   // Loop outputs change only after a clock edge
   always_ff @(posedge clk_sys) begin
      field_loop_angle <= angle_req;
      emf_loop_demand  <= demand_req;
   end
   // Distinct values so a wrong source shows
   assign speed_err_integral   = 11'h123;
   assign final_current_demand = 11'h456;
   assign bridge_full = full_control & BRIDGE_MODE_LINK;
endmodule : mfc_bridge_model

/* File: testbench/mfc_field_ctrl_tb.sv */
// Self-checking bench for the motor field control block
`timescale 1ns/1ps
`include "mfc_params.svh"
module mfc_field_ctrl_tb;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        drive_enable = 1'b1;
   logic [9:0]  angle_req = 10'h000, demand_req = 10'h000;
   logic [9:0]  emf_d, loop_ang, field_demand, firing_angle, sg_num, sg_den;
   logic [10:0] sei, fcd, ir_comp_input;
   logic [2:0]  field_gain_shift;
   logic        boost, vdbl, full_control, loop_bypass, bridge_full;
   int          mismatches = 0, samples_checked = 0, cycles = 0;
   logic [31:0] rd;
   logic [1:0]  rsp;

   always #5 clk_sys = ~clk_sys;

   mfc_field_ctrl #(.CYC_PER_SEC(10), .EARLY_CARD(1'b1)) dut (
      .clk_sys(clk_sys), .rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_enable(drive_enable),
      .emf_loop_demand(emf_d), .field_loop_angle(loop_ang),
      .speed_err_integral(sei), .final_current_demand(fcd),
      .field_demand(field_demand), .firing_angle(firing_angle),
      .ir_comp_input(ir_comp_input), .field_gain_shift(field_gain_shift),
      .field_integral_boost(boost), .voltage_integral_double(vdbl),
      .full_control(full_control), .loop_bypass(loop_bypass),
      .speed_gain_num(sg_num), .speed_gain_den(sg_den));

   mfc_bridge_model #(.BRIDGE_MODE_LINK(1'b1)) far_side (
      .clk_sys(clk_sys), .full_control(full_control), .angle_req(angle_req),
      .demand_req(demand_req), .field_loop_angle(loop_ang),
      .emf_loop_demand(emf_d), .speed_err_integral(sei),
      .final_current_demand(fcd), .bridge_full(bridge_full));

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic report_and_stop;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // Address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp_rsp);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      check("bresp", {30'h0, bresp}, {30'h0, exp_rsp});
      repeat (3) @(posedge clk_sys);
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd  = rdata;
      rsp = rresp;
      rready <= 1'b0;
      check("rdata", rd, exp);
      check("rresp", {30'h0, rsp}, {30'h0, er});
      @(posedge clk_sys);
   endtask : rdchk

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rdchk(`MFC_OFF_ECON_DELAY, 32'h1e, 2'h0);
      rdchk(`MFC_OFF_CTRL, 32'h008, 2'h0);
      rdchk(`MFC_OFF_FIRE_LIMIT, 32'h3e8, 2'h0);
      rdchk(12'h100, 32'h0, 2'h2);
      wr(12'h100, 32'h0, 2'h2);
      wr(`MFC_OFF_FB_SCALE, 32'h64, 2'h0);
      rdchk(`MFC_OFF_FB_SCALE, `MFC_FB_RESET, 2'h0);
      wr(`MFC_OFF_FB_SCALE, 32'h65, 2'h0);
      rdchk(`MFC_OFF_FB_SCALE, 32'h65, 2'h0);
      wr(`MFC_OFF_FB_SCALE, 32'h6e, 2'h0);
      wr(`MFC_OFF_FB_SCALE, 32'h6f, 2'h0);
      rdchk(`MFC_OFF_FB_SCALE, 32'h6e, 2'h0);
      $display("test reset values done");
      wr(`MFC_OFF_MAX1, 32'h320, 2'h0);
      wr(`MFC_OFF_MIN, 32'h0c8, 2'h0);
      demand_req <= 10'h384;
      wr(`MFC_OFF_CTRL, 32'h009, 2'h0);
      check("demand max1", field_demand, 10'h320);
      check("gain num", sg_num, 10'h320);
      check("gain den", sg_den, 10'h320);
      wr(`MFC_OFF_CTRL, 32'h00b, 2'h0);
      check("demand max2", field_demand, 10'h1f4);
      check("gain den max2", sg_den, 10'h1f4);
      demand_req <= 10'h064;
      repeat (4) @(posedge clk_sys);
      check("demand min", field_demand, 10'h0c8);
      demand_req <= 10'h384;
      $display("test demand limits done");
      // Endstop below the loop angle, chosen as a configurer would
      wr(`MFC_OFF_FIRE_LIMIT, 32'h258, 2'h0);
      wr(`MFC_OFF_FIRE_LIMIT, 32'h3e9, 2'h0);
      rdchk(`MFC_OFF_FIRE_LIMIT, 32'h258, 2'h0);
      angle_req <= 10'h384;
      repeat (4) @(posedge clk_sys);
      check("angle stop", firing_angle, 10'h258);
      check("no bypass", loop_bypass, 1'b0);
      wr(`MFC_OFF_MAX2, 32'h2bc, 2'h0);
      wr(`MFC_OFF_CTRL, 32'h029, 2'h0);
      check("direct stop", firing_angle, 10'h258);
      check("bypass", loop_bypass, 1'b1);
      wr(`MFC_OFF_MAX2, 32'h190, 2'h0);
      check("direct angle", firing_angle, 10'h190);
      $display("test firing angle done");
      for (int i = 0; i < 4; i++) begin
         wr(`MFC_OFF_CTRL, 32'h009 | (i << 8), 2'h0);
         check("gain shift", field_gain_shift, i[2:0]);
      end
      wr(`MFC_OFF_CTRL, 32'h0d1, 2'h0);
      check("boost", boost, 1'b1);
      check("vdouble", vdbl, 1'b1);
      check("full", full_control, 1'b1);
      check("link full", bridge_full, 1'b1);
      check("ir src1", ir_comp_input, 11'h456);
      wr(`MFC_OFF_CTRL, 32'h009, 2'h0);
      check("ir src0", ir_comp_input, 11'h123);
      check("normal", {boost, vdbl, full_control}, 3'h0);
      $display("test mode bits done");
      wr(`MFC_OFF_MAX2, 32'h1f4, 2'h0);
      wr(`MFC_OFF_ECON_DELAY, 32'h03, 2'h0);
      wr(`MFC_OFF_CTRL, 32'h00f, 2'h0);
      check("econ enabled", field_demand, 10'h320);
      drive_enable <= 1'b0;
      repeat (20) @(posedge clk_sys);
      check("econ early", field_demand, 10'h320);
      repeat (30) @(posedge clk_sys);
      check("econ late", field_demand, 10'h1f4);
      drive_enable <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("econ clear", field_demand, 10'h320);
      wr(`MFC_OFF_CTRL, 32'h00b, 2'h0);
      drive_enable <= 1'b0;
      repeat (50) @(posedge clk_sys);
      check("manual kept", field_demand, 10'h1f4);
      wr(`MFC_OFF_CTRL, 32'h009, 2'h0);
      check("manual off", field_demand, 10'h320);
      $display("test economy done");
      report_and_stop();
   end
endmodule : mfc_field_ctrl_tb
